/* hdl/rom_io_pkg.sv */
// Constants and carrier types shared by the ROM-unit peripheral block
`default_nettype none
package rom_io_pkg;
	// Port selection by the two low address bits
	localparam int SELECT_W = 6;
	localparam logic [1:0] SEL_PORT_A = 2'h0;
	localparam logic [1:0] SEL_PORT_B = 2'h1;
	localparam logic [1:0] SEL_INT_CTRL = 2'h2;
	localparam logic [1:0] SEL_TIMER = 2'h3;
	// Address bit 8 opens the local status and mask space
	localparam int LOCAL_SPACE_BIT = 8;
	localparam logic [1:0] LOC_STATUS = 2'h0;
	localparam logic [1:0] LOC_MASK = 2'h1;
	// Event bits, shared by status, mask and interrupt control
	localparam int EV_TIMER = 0;
	localparam int EV_EXTERNAL = 1;
	localparam int EV_W = 2;
	localparam logic [EV_W-1:0] EV_NONE = 2'h0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// Timer polynomial: xnor feedback, all-zero state is the end of count
	localparam logic [7:0] TIMER_TAPS = 8'hb8;
	localparam logic [7:0] TIMER_TERMINAL = 8'h00;
	// Timer step interval
	localparam int CLK_PERIOD_NS = 100;
	localparam int TIMER_STEP_NS = 1000;
	localparam int TIMER_STEP_CYCLES = (TIMER_STEP_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// Control-state code that acknowledges an interrupt
	localparam logic [4:0] ACK_CODE = 5'h10;

	// Drive of an eight-bit open-drain port
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} pin_drive_t;
endpackage
`default_nettype wire

/* hdl/lfsr_interval_timer.sv */
// Polynomial shift-register interval timer with reload
`default_nettype none
module lfsr_interval_timer
	import rom_io_pkg::*;
#(
	parameter int STEP_CYCLES = TIMER_STEP_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic load,
	input wire logic [7:0] loadValue,
	output logic [7:0] state,
	output logic timeout
);
	localparam int PW = $clog2(STEP_CYCLES + 1);
	localparam logic [PW-1:0] PRE_LAST = PW'(STEP_CYCLES - 1);
	localparam logic [PW-1:0] PRE_ZERO = '0;

	// One shift of the polynomial register
	function automatic logic [7:0] stepLfsr(input logic [7:0] s);
		stepLfsr = {s[6:0], ~(^(s & TIMER_TAPS))};
	endfunction

	logic [7:0] reload;
	logic running;
	logic [PW-1:0] pre;
	logic timeoutReg;
	wire tick = running && (pre == PRE_LAST);
	wire atEnd = state == TIMER_TERMINAL;

	assign timeout = timeoutReg;

	// Prescaler, run flag and time-out, clocked from the common clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			running <= 1'b0;
			pre <= PRE_ZERO;
			timeoutReg <= 1'b0;
		end else begin
			running <= running | load;
			pre <= (load || tick) ? PRE_ZERO : pre + PW'(1);
			timeoutReg <= tick && atEnd && !load;
		end
	end

	// Count and reload value hold no reset value
	always_ff @(posedge clk) begin
		if (load) begin
			state <= loadValue;
			reload <= loadValue;
		end else if (tick) begin
			state <= atEnd ? reload : stepLfsr(state);
		end
	end

	// Count steps once per tick and reloads at its end
	a_count_steps: assert property (@(posedge clk)
		disable iff (!rst_n)
		tick && !load && !atEnd |=> state == stepLfsr($past(state)))
		else $error("timer count did not take one polynomial step");

	a_end_reloads: assert property (@(posedge clk)
		disable iff (!rst_n)
		tick && !load && atEnd |=> state == $past(reload))
		else $error("timer did not reload at end of count");
endmodule
`default_nettype wire

/* hdl/rom_unit_io_timer_interrupt.sv */
// ROM-unit peripherals: two ports, timer, interrupt control and chain
// How it works
// - Timer and external input raise requests, passed on through the chain.
// - Timer is a polynomial shift register; its end of count raises a time-out.
// - Writing the timer port loads it and sets the time-out interval.
// - Fixed six-bit select must match the upper address bits to respond.
// - Low address bits pick port A, port B, interrupt control, timer.
// - Ports are inverted: written one pulls the pin low, low reads one.
// - Ports, timer and interrupt control are not initialised by reset; here reset turns off port drive, timer and enables until written.
// - Falling edge on the external input is a request.
// - Request pin pulled low only with chain input low and request pending.
// - Chain output low only with chain input low and nothing pending.
// - Bus-drive indicator pulled low exactly while data bus is driven.
// - Data moves on an eight-bit three-state shared bus.
//
// Our own choices: the placing of the registers and the plain strobed port.
`default_nettype none
module rom_unit_io_timer_interrupt
	import rom_io_pkg::*;
#(
	parameter logic [SELECT_W-1:0] IO_SELECT = 6'h02,
	parameter int STEP_CYCLES = TIMER_STEP_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [8:0] ioAddr,
	input wire logic [7:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	output logic [7:0] sharedDataOut,
	output logic sharedDataOe,
	output logic busDriveIndicatorOut,
	output logic busDriveIndicatorOe,
	input wire logic [7:0] portAIn,
	output var pin_drive_t portADrive,
	input wire logic [7:0] portBIn,
	output var pin_drive_t portBDrive,
	input wire logic externalInterruptInput,
	input wire logic priorityChainIn,
	output logic priorityChainOut,
	output logic intReqOut,
	output logic intReqOe,
	input wire logic [4:0] cpuControlStateCode,
	input wire logic controlStateValid,
	output logic irq
);
	// True when the address reaches one of the four ports and names sel
	function automatic logic portHit(input logic [8:0] a,
		input logic [1:0] sel);
		portHit = !a[LOCAL_SPACE_BIT] && (a[7:2] == IO_SELECT)
			&& (a[1:0] == sel);
	endfunction

	// True when the address reaches the local register named loc
	function automatic logic localHit(input logic [8:0] a,
		input logic [1:0] loc);
		localHit = a[LOCAL_SPACE_BIT] && (a[7:2] == 6'h00) && (a[1:0] == loc);
	endfunction

	// Port latches and interrupt control, no reset value
	logic [7:0] portALatch;
	logic [7:0] portBLatch;
	logic [EV_W-1:0] intCtrl;
	// Flags that say a port has been written since reset
	logic portAWritten;
	logic portBWritten;
	logic intCtrlWritten;
	logic [EV_W-1:0] status;
	logic [EV_W-1:0] mask;
	logic extPrev;
	logic readValid;
	logic [7:0] readData;
	logic [7:0] timerState;
	logic timerTimeout;

	// Address decode
	wire wrPortA = wrStrobe && portHit(ioAddr, SEL_PORT_A);
	wire wrPortB = wrStrobe && portHit(ioAddr, SEL_PORT_B);
	wire wrIntCtrl = wrStrobe && portHit(ioAddr, SEL_INT_CTRL);
	wire wrTimer = wrStrobe && portHit(ioAddr, SEL_TIMER);
	wire wrStatus = wrStrobe && localHit(ioAddr, LOC_STATUS);
	wire wrMask = wrStrobe && localHit(ioAddr, LOC_MASK);
	wire rdHit = rdStrobe && !ioAddr[LOCAL_SPACE_BIT]
		&& (ioAddr[7:2] == IO_SELECT);
	wire rdLocal = rdStrobe && ioAddr[LOCAL_SPACE_BIT]
		&& (ioAddr[7:2] == 6'h00);

	// Read selection; pins read inverted
	wire [7:0] portRead = (ioAddr[1:0] == SEL_PORT_A) ? ~portAIn :
		(ioAddr[1:0] == SEL_PORT_B) ? ~portBIn :
		(ioAddr[1:0] == SEL_INT_CTRL) ? {6'h00, intCtrl} : timerState;
	wire [7:0] localRead = (ioAddr[1:0] == LOC_STATUS) ? {6'h00, status} :
		(ioAddr[1:0] == LOC_MASK) ? {6'h00, mask} : BYTE_ZERO;
	wire [7:0] next_readData = rdHit ? portRead :
		rdLocal ? localRead : BYTE_ZERO;

	// Event detection and enables
	wire extFall = extPrev && !externalInterruptInput;
	wire [EV_W-1:0] enables = intCtrlWritten ? intCtrl : EV_NONE;
	wire [EV_W-1:0] events = {extFall, timerTimeout} & enables;
	wire pending = |(status & mask);

	// Acknowledge retires the timer request first, then the external one
	wire ackSeen = controlStateValid && (cpuControlStateCode == ACK_CODE)
		&& intReqOe;
	wire [EV_W-1:0] ackClear = !ackSeen ? EV_NONE :
		(status[EV_TIMER] && mask[EV_TIMER]) ? 2'h1 : 2'h2;
	wire [EV_W-1:0] wrClear = wrStatus ? wrData[EV_W-1:0] : EV_NONE;
	// Set wins over a clear in the same cycle
	wire [EV_W-1:0] next_status = (status & ~(ackClear | wrClear)) | events;

	// Priority chain and request pin
	assign intReqOut = 1'b0;
	assign intReqOe = pending && !priorityChainIn;
	assign priorityChainOut = priorityChainIn || pending;
	assign irq = pending;

	// Data bus drive and bus-drive indicator
	assign sharedDataOut = readData;
	assign sharedDataOe = readValid;
	assign busDriveIndicatorOut = 1'b0;
	assign busDriveIndicatorOe = readValid;

	// Open-drain port drive, gated until first written
	assign portADrive.out = BYTE_ZERO;
	assign portADrive.oe = portAWritten ? portALatch : BYTE_ZERO;
	assign portBDrive.out = BYTE_ZERO;
	assign portBDrive.oe = portBWritten ? portBLatch : BYTE_ZERO;

	lfsr_interval_timer #(
		.STEP_CYCLES(STEP_CYCLES)
	) timerUnit (
		.clk(clk),
		.rst_n(rst_n),
		.load(wrTimer),
		.loadValue(wrData),
		.state(timerState),
		.timeout(timerTimeout)
	);

	// Data latches keep no reset value
	always_ff @(posedge clk) begin
		if (wrPortA) begin
			portALatch <= wrData;
		end
		if (wrPortB) begin
			portBLatch <= wrData;
		end
		if (wrIntCtrl) begin
			intCtrl <= wrData[EV_W-1:0];
		end
	end

	// Control state, status and read pipeline
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			portAWritten <= 1'b0;
			portBWritten <= 1'b0;
			intCtrlWritten <= 1'b0;
			status <= EV_NONE;
			mask <= EV_NONE;
			extPrev <= 1'b1;
			readValid <= 1'b0;
			readData <= BYTE_ZERO;
		end else begin
			portAWritten <= portAWritten | wrPortA;
			portBWritten <= portBWritten | wrPortB;
			intCtrlWritten <= intCtrlWritten | wrIntCtrl;
			status <= next_status;
			mask <= wrMask ? wrData[EV_W-1:0] : mask;
			extPrev <= externalInterruptInput;
			readValid <= rdHit || rdLocal;
			readData <= next_readData;
		end
	end

	// Chain and request pin checks
	a_prio_out_low: assert property (@(posedge clk)
		disable iff (!rst_n)
		!priorityChainOut |-> !priorityChainIn && !pending)
		else $error("chain output low with request or chain input high");

	a_chain_passes: assert property (@(posedge clk)
		disable iff (!rst_n)
		!priorityChainIn && !pending |-> !priorityChainOut)
		else $error("chain output high with grant and nothing pending");

	a_chain_blocks: assert property (@(posedge clk)
		disable iff (!rst_n)
		priorityChainIn |-> priorityChainOut && !intReqOe)
		else $error("request or grant passed on without chain input");

	a_req_needs_chain: assert property (@(posedge clk)
		disable iff (!rst_n)
		intReqOe |-> !priorityChainIn && |(status & mask))
		else $error("request pin pulled without chain grant");

	a_open_drain_low: assert property (@(posedge clk)
		disable iff (!rst_n)
		portADrive.out == BYTE_ZERO && portBDrive.out == BYTE_ZERO
		&& !intReqOut && !busDriveIndicatorOut)
		else $error("open-drain pin driven high");

	// Data bus and bus-drive indicator checks
	a_drive_pairs_bus: assert property (@(posedge clk)
		disable iff (!rst_n)
		busDriveIndicatorOe == sharedDataOe)
		else $error("bus-drive indicator out of step with data bus");

	a_read_drives: assert property (@(posedge clk)
		disable iff (!rst_n)
		rdHit |=> sharedDataOe && busDriveIndicatorOe)
		else $error("read that hit did not drive the bus");

	a_read_one_later: assert property (@(posedge clk)
		disable iff (!rst_n)
		rdHit |=> sharedDataOe ##1 (!sharedDataOe || $past(rdStrobe)))
		else $error("read data not driven for exactly the next cycle");

	a_idle_bus_zero: assert property (@(posedge clk)
		disable iff (!rst_n)
		!sharedDataOe |-> sharedDataOut == BYTE_ZERO)
		else $error("data lines not zero while bus released");

	// Address select checks
	a_foreign_quiet: assert property (@(posedge clk)
		disable iff (!rst_n)
		rdStrobe && !ioAddr[LOCAL_SPACE_BIT] && ioAddr[7:2] != IO_SELECT
		|=> !sharedDataOe)
		else $error("bus driven for a foreign port address");

	a_foreign_write: assert property (@(posedge clk)
		disable iff (!rst_n)
		wrStrobe && !ioAddr[LOCAL_SPACE_BIT] && ioAddr[7:2] != IO_SELECT
		|=> $stable(portADrive.oe) && $stable(portBDrive.oe))
		else $error("port drive changed by a foreign port write");

	// Port polarity checks
	a_port_inverts: assert property (@(posedge clk)
		disable iff (!rst_n)
		rdHit && ioAddr[1:0] == SEL_PORT_A |=> sharedDataOut
		== ~$past(portAIn))
		else $error("port A read not inverted");

	a_port_pulls_low: assert property (@(posedge clk)
		disable iff (!rst_n)
		wrPortB |=> portBDrive.oe == $past(wrData))
		else $error("port B drive does not follow written ones");

	// Request latch checks
	a_edge_latches: assert property (@(posedge clk)
		disable iff (!rst_n)
		extFall && enables[EV_EXTERNAL] |=> status[EV_EXTERNAL])
		else $error("external falling edge not latched");

	a_held_till_ack: assert property (@(posedge clk)
		disable iff (!rst_n)
		status[EV_TIMER] && !ackSeen && !(wrStatus && wrData[EV_TIMER])
		|=> status[EV_TIMER])
		else $error("timer request lost without acknowledge");

	a_ack_retires: assert property (@(posedge clk)
		disable iff (!rst_n)
		ackSeen && !(status[EV_TIMER] && mask[EV_TIMER])
		&& !events[EV_EXTERNAL] |=> !status[EV_EXTERNAL])
		else $error("acknowledge did not retire the external request");

	a_write_clears: assert property (@(posedge clk)
		disable iff (!rst_n)
		wrStatus && wrData[EV_EXTERNAL] && !events[EV_EXTERNAL]
		|=> !status[EV_EXTERNAL])
		else $error("writing a one did not clear the external request");

	// Timer checks
	a_timeout_sets: assert property (@(posedge clk)
		disable iff (!rst_n)
		timerTimeout && enables[EV_TIMER] |=> status[EV_TIMER])
		else $error("timer end of count not latched");

	a_timer_loads: assert property (@(posedge clk)
		disable iff (!rst_n)
		wrTimer |=> timerState == $past(wrData))
		else $error("timer port write did not load the count");
endmodule
`default_nettype wire

/* verification/port_far_side.sv */
// External logic on the two open-drain ports, with pull-ups
`default_nettype none
module port_far_side
	import rom_io_pkg::*;
(
	input wire pin_drive_t driveA,
	input wire pin_drive_t driveB,
	input wire logic [7:0] pullA,
	input wire logic [7:0] pullB,
	output logic [7:0] pinA,
	output logic [7:0] pinB
);
	// A pin is low when either side pulls it, else the pull-up wins
	assign pinA = ~(driveA.oe | pullA);
	assign pinB = ~(driveB.oe | pullB);
endmodule
`default_nettype wire

/* verification/rom_unit_io_timer_interrupt_tb_top.sv */
// Self-checking bench for the ROM-unit ports, timer and interrupt chain
`default_nettype none
module rom_unit_io_timer_interrupt_tb_top
	import rom_io_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [5:0] SEL = 6'h02;
	logic clk, rst_n, wrStrobe, rdStrobe, sharedDataOe, busDriveIndicatorOut;
	logic busDriveIndicatorOe, externalInterruptInput, priorityChainIn;
	logic priorityChainOut, intReqOut, intReqOe, controlStateValid, irq;
	logic [8:0] ioAddr;
	logic [7:0] wrData, sharedDataOut, portAIn, portBIn, pullA, pullB, v, d;
	logic [4:0] cpuControlStateCode;
	logic oeSeen;
	pin_drive_t portADrive, portBDrive;
	logic [31:0] seed = 32'h93223064;
	int errorCnt = 0, nCompared = 0, n, cnt;

	rom_unit_io_timer_interrupt #(.IO_SELECT(SEL), .STEP_CYCLES(1)) dut (
		.clk(clk), .rst_n(rst_n), .ioAddr(ioAddr), .wrData(wrData),
		.wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
		.sharedDataOut(sharedDataOut), .sharedDataOe(sharedDataOe),
		.busDriveIndicatorOut(busDriveIndicatorOut),
		.busDriveIndicatorOe(busDriveIndicatorOe), .portAIn(portAIn),
		.portADrive(portADrive), .portBIn(portBIn), .portBDrive(portBDrive),
		.externalInterruptInput(externalInterruptInput),
		.priorityChainIn(priorityChainIn), .priorityChainOut(priorityChainOut),
		.intReqOut(intReqOut), .intReqOe(intReqOe),
		.cpuControlStateCode(cpuControlStateCode),
		.controlStateValid(controlStateValid), .irq(irq));
	port_far_side far (.driveA(portADrive), .driveB(portBDrive),
		.pullA(pullA), .pullB(pullB), .pinA(portAIn), .pinB(portBIn));

	// Host-supplied clock at 100 ns
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// One step of the timer polynomial, from its taps
	function logic [7:0] nxt(input logic [7:0] s);
		return {s[6:0], ~^(s & TIMER_TAPS)};
	endfunction
	// Steps from a load value down to the all-zero state, plus the end step
	function int steps(input logic [7:0] s);
		int k;
		k = 1;
		while (s !== TIMER_TERMINAL && k < 300) begin
			s = nxt(s);
			k++;
		end
		return k;
	endfunction
	function logic [8:0] pa(input logic [1:0] s);
		return {1'b0, SEL, s};
	endfunction
	task check(input string what, input logic [31:0] seen, exp);
		nCompared++;
		if (seen !== exp) begin
			errorCnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input logic [8:0] a, input logic [7:0] x);
		ioAddr <= a;
		wrData <= x;
		wrStrobe <= 1'b1;
		@(posedge clk);
		wrStrobe <= 1'b0;
		@(posedge clk);
	endtask
	task rd(input logic [8:0] a, output logic [7:0] x);
		ioAddr <= a;
		rdStrobe <= 1'b1;
		@(posedge clk);
		rdStrobe <= 1'b0;
		@(negedge clk);
		x = sharedDataOut;
		oeSeen = sharedDataOe;
		check("bus_drive_indicator", busDriveIndicatorOe, sharedDataOe);
		check("bus_drive_indicator level", busDriveIndicatorOut, 1'b0);
		@(posedge clk);
	endtask
	task conclude();
		$display("compared %0d mismatches %0d", nCompared, errorCnt);
		if (errorCnt == 0 && nCompared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Watchdog against a hung wait
	initial begin
		#(100 * 20000);
		errorCnt++;
		conclude();
	end

	// Main sequence
	initial begin
		{rst_n, wrStrobe, rdStrobe, controlStateValid} = 4'h0;
		{ioAddr, wrData, pullA, pullB, cpuControlStateCode} = '0;
		externalInterruptInput = 1'b1;
		priorityChainIn = 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		check("reset bus", {sharedDataOe, busDriveIndicatorOe}, 2'h0);
		check("reset ports", {portADrive.oe, portBDrive.oe}, 16'h0);
		check("reset irq", {irq, intReqOe}, 2'h0);
		@(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 12; i++) begin
			v = (i == 0) ? 8'hff : 8'(rnd());
			d = 8'(rnd());
			if (i[0]) pullB <= d; else pullA <= d;
			wr(pa({1'b0, i[0]}), v);
			check("drive", i[0] ? portBDrive : portADrive, {8'h0, v});
			rd(pa({1'b0, i[0]}), d);
			check("port read", d, v | (i[0] ? pullB : pullA));
			check("bus oe", oeSeen, 1'b1);
		end
		v = portADrive.oe;
		wr({1'b0, SEL ^ 6'h01, 2'b00}, ~v);
		check("foreign write", portADrive.oe, v);
		rd({1'b0, SEL ^ 6'h10, 2'b00}, d);
		check("foreign read", {oeSeen, d}, 9'h0);
		// Reset in mid-run drops port drive until the next write
		rst_n <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		check("rerun ports", {portADrive.oe, portBDrive.oe}, 16'h0);
		@(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		$display("test ports done");
		wr(pa(SEL_INT_CTRL), 8'h02);
		rd(pa(SEL_INT_CTRL), d);
		check("int ctrl", d, 8'h02);
		wr(9'h101, 8'h02);
		wr(9'h100, 8'h03);
		for (int j = 0; j < 2; j++) begin
			externalInterruptInput <= 1'b0;
			repeat (3) @(posedge clk);
			@(negedge clk);
			check("ext irq", irq, 1'b1);
			check("req blocked", {intReqOe, priorityChainOut}, 2'h1);
			@(posedge clk);
			priorityChainIn <= 1'b0;
			@(negedge clk);
			check("req out", {intReqOe, priorityChainOut}, 2'h3);
			check("req level", intReqOut, 1'b0);
			@(posedge clk);
			rd(9'h100, d);
			check("status", d, 8'h02);
			if (j == 0) begin
				cpuControlStateCode <= ACK_CODE;
				controlStateValid <= 1'b1;
				@(posedge clk);
				controlStateValid <= 1'b0;
				@(posedge clk);
			end else
				wr(9'h100, 8'h02);
			@(negedge clk);
			check("cleared", {irq, intReqOe, priorityChainOut}, 3'h0);
			@(posedge clk);
			externalInterruptInput <= 1'b1;
			priorityChainIn <= 1'b1;
			@(posedge clk);
		end
		$display("test interrupt done");
		wr(pa(SEL_INT_CTRL), 8'h01);
		wr(9'h101, 8'h01);
		for (int t = 0; t < 4; t++) begin
			do v = 8'(rnd()); while (v == 8'hff || steps(v) < 8);
			n = steps(v);
			wr(pa(SEL_TIMER), v);
			wr(9'h100, 8'h01);
			cnt = 4;
			while (irq !== 1'b1 && cnt < 400) begin
				@(negedge clk);
				cnt++;
			end
			check("timeout", cnt, n + 3);
			@(posedge clk);
		end
		// Reading the timer port returns the count one step after loading
		wr(pa(SEL_TIMER), 8'h5a);
		rd(pa(SEL_TIMER), d);
		check("timer read", d, nxt(8'h5a));
		$display("test timer done");
		conclude();
	end
endmodule
`default_nettype wire
